/* hw/pipe_pcs_lane.sv */
// One lane of the parallel-interface coding layer: 8b10b, elastic buffer, power control.
// Behaviour
// - All interface signals live on one clock.
// - Forty-bit word; hardened mode ignores top byte.
// - Bytes go lowest first, highest last.
// - Encode and decode bytes with 8b10b.
// - Elastic buffer adjusts by skip characters.
// - Translate power state, run detect and changes.
// - Detect input in P1 starts receiver detection.
// - Detect input in P0 enters loopback.
// - Compliance forces running disparity negative.
// - Compliance plus idle turns lane off.
// - Recovery reference selectable fabric or pin.
// - Two-bit select picks P0, P0s, P1, P2.
// - Idle input forces electrical idle always.
// - Polarity input inverts received data.
`timescale 1ns/1ns
`include "pipe_lane_regs.svh"
module pipe_pcs_lane
    import pipe_lane_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Transmit words from the controller.
    input wire logic [39:0] tx_data_i,
    input wire logic [3:0] lane_tx_ctrl_flags_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic soft_ctrl_mode_i,
    // Lane control from the controller.
    input wire logic [1:0] power_state_select_i,
    input wire logic tx_idle_force_i,
    input wire logic compliance_disparity_force_i,
    input wire logic lane_detect_or_loopback_i,
    input wire logic rx_polarity_flip_i,
    input wire logic lane_recovery_ref_from_fabric_i,
    // Status to the controller.
    output logic phy_status_o,
    output logic receiver_detected_o,
    output logic loopback_active_o,
    // Attachment side.
    output symbol_t tx_symbol_o,
    output logic tx_symbol_valid_o,
    output logic tx_elec_idle_o,
    output logic lane_off_o,
    output logic [1:0] pma_power_o,
    output logic cdr_ref_from_fabric_o,
    output logic pma_detect_en_o,
    input wire logic pma_rx_present_i,
    input wire logic [9:0] rx_symbol_i,
    input wire logic rx_symbol_valid_i,
    // Received bytes to the controller.
    output logic [7:0] rx_data_o,
    output logic rx_ctrl_flag_o,
    output logic rx_code_err_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i
);
    localparam logic [7:0] DET_LOAD = 8'(`DETECT_CYCLES - 1);
    localparam int DET_MAX = 140;

    // 5b/6b code for the negative running disparity column.
    function automatic logic [5:0] code6(input logic [4:0] x);
        case (x)
            5'h00: code6 = 6'b100111; 5'h01: code6 = 6'b011101;
            5'h02: code6 = 6'b101101; 5'h03: code6 = 6'b110001;
            5'h04: code6 = 6'b110101; 5'h05: code6 = 6'b101001;
            5'h06: code6 = 6'b011001; 5'h07: code6 = 6'b111000;
            5'h08: code6 = 6'b111001; 5'h09: code6 = 6'b100101;
            5'h0A: code6 = 6'b010101; 5'h0B: code6 = 6'b110100;
            5'h0C: code6 = 6'b001101; 5'h0D: code6 = 6'b101100;
            5'h0E: code6 = 6'b011100; 5'h0F: code6 = 6'b010111;
            5'h10: code6 = 6'b011011; 5'h11: code6 = 6'b100011;
            5'h12: code6 = 6'b010011; 5'h13: code6 = 6'b110010;
            5'h14: code6 = 6'b001011; 5'h15: code6 = 6'b101010;
            5'h16: code6 = 6'b011010; 5'h17: code6 = 6'b111010;
            5'h18: code6 = 6'b110011; 5'h19: code6 = 6'b100110;
            5'h1A: code6 = 6'b010110; 5'h1B: code6 = 6'b110110;
            5'h1C: code6 = 6'b001110; 5'h1D: code6 = 6'b101110;
            5'h1E: code6 = 6'b011110; 5'h1F: code6 = 6'b101011;
            default: code6 = 6'b000000;
        endcase
    endfunction : code6

    // 3b/4b code for the negative column; code 7 is the primary form.
    function automatic logic [3:0] code4(input logic [2:0] y);
        case (y)
            3'h0: code4 = 4'b1011; 3'h1: code4 = 4'b1001;
            3'h2: code4 = 4'b0101; 3'h3: code4 = 4'b1100;
            3'h4: code4 = 4'b1101; 3'h5: code4 = 4'b1010;
            3'h6: code4 = 4'b0110; 3'h7: code4 = 4'b1110;
            default: code4 = 4'b0000;
        endcase
    endfunction : code4

    // Returns {running disparity after, abcdei, fghj}; rd high means positive.
    function automatic logic [10:0] enc8b10b(input logic [7:0] b, input logic k,
                                             input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic rd1;
        logic alt;
        logic k28;
        k28 = k && (b[4:0] == 5'h1C);
        s6 = k28 ? 6'b001111 : code6(b[4:0]);
        if (rd && (($countones(s6) != 3) || (b[4:0] == 5'h07))) begin
            s6 = ~s6;
        end
        rd1 = ($countones(s6) != 3) ? ~rd : rd;
        alt = (b[7:5] == 3'h7) && (k || (!rd1 && (b[4:0] inside {5'h11, 5'h12, 5'h14}))
              || (rd1 && (b[4:0] inside {5'h0B, 5'h0D, 5'h0E})));
        s4 = alt ? 4'b0111 : code4(b[7:5]);
        if (rd1 && (($countones(s4) != 2) || (b[7:5] == 3'h3))) begin
            s4 = ~s4;
        end
        if (k28 && !rd1 && (b[7:5] inside {3'h1, 3'h2, 3'h5, 3'h6})) begin
            s4 = ~s4;
        end
        enc8b10b = {(($countones(s4) != 2) ? ~rd1 : rd1), s6, s4};
    endfunction : enc8b10b

    // Returns {code error, control, byte}; accepts either disparity column.
    function automatic logic [9:0] dec8b10b(input logic [9:0] sym);
        logic [9:0] r;
        logic [10:0] c;
        r = 10'h200;
        // Walk downward so that a data reading beats a control reading.
        for (int i = 511; i >= 0; i--) begin
            for (int p = 0; p < 2; p++) begin
                c = enc8b10b(8'(i), i[8], p[0]);
                if (c[9:0] == sym) begin
                    r = {1'b0, i[8], 8'(i)};
                end
            end
        end
        dec8b10b = r;
    endfunction : dec8b10b

    power_state_e pstate;
    logic lane_off_req;
    logic tx_enable;
    logic q_valid;
    logic q_ready;
    logic [44:0] q_data;
    tx_state_e tx_state;
    logic [44:0] word;
    logic [2:0] idx;
    logic last_byte;
    logic [3:0] kflags;
    logic [7:0] cur_byte;
    logic cur_k;
    logic [10:0] enc;
    logic rd;
    logic comp_q;

    // The select is taken as-is; every input here is already on clk_i.
    assign pstate = power_state_e'(power_state_select_i);
    assign lane_off_req = compliance_disparity_force_i && tx_idle_force_i;
    // Words move only in P0, out of idle and out of loopback; else the queue backs up.
    assign tx_enable = (pstate == PWR_P0) && !tx_idle_force_i && !lane_off_req
                       && !loopback_active_o;

    // Power translation and idle control are registered so the attachment sees clean levels.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lane_off_o <= 1'b0;
            tx_elec_idle_o <= 1'b1;
            pma_power_o <= PWR_P1;
            cdr_ref_from_fabric_o <= 1'b0;
        end else begin
            lane_off_o <= lane_off_req;
            tx_elec_idle_o <= tx_idle_force_i || (pstate != PWR_P0) || lane_off_req;
            pma_power_o <= lane_off_req ? PWR_P2 : pstate;
            cdr_ref_from_fabric_o <= lane_recovery_ref_from_fabric_i;
        end
    end

    // Hardened mode zeroes the fifth byte so it can never reach the line.
    lane_fifo #(
        .WIDTH(45),
        .DEPTH(`TXQ_DEPTH)
    ) tx_queue (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i({soft_ctrl_mode_i, lane_tx_ctrl_flags_i,
                    soft_ctrl_mode_i ? tx_data_i[39:32] : 8'h00, tx_data_i[31:0]}),
        .out_valid_o(q_valid),
        .out_ready_i(q_ready),
        .out_data_o(q_data),
        .level_o()
    );

    // Current byte, lowest first; the fifth byte is always data.
    assign kflags = word[43:40];
    assign cur_byte = word[{idx, 3'b000} +: 8];
    assign cur_k = idx[2] ? 1'b0 : kflags[idx[1:0]];
    assign last_byte = (idx == (word[44] ? `LAST_BYTE_SOFT : `LAST_BYTE_HARD));
    assign enc = enc8b10b(cur_byte, cur_k, rd);
    assign q_ready = tx_enable && ((tx_state == TX_IDLE) || last_byte);

    // Word serializer: the next word loads in the cycle the last byte goes out.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_state <= TX_IDLE;
            word <= '0;
            idx <= 3'h0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (q_valid && q_ready) begin
                        word <= q_data;
                        idx <= 3'h0;
                        tx_state <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (tx_enable && last_byte) begin
                        idx <= 3'h0;
                        if (q_valid) begin
                            word <= q_data;
                        end else begin
                            tx_state <= TX_IDLE;
                        end
                    end else if (tx_enable) begin
                        idx <= idx + 3'h1;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // Running disparity; a rising compliance input resets it to negative.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd <= 1'b0;
            comp_q <= 1'b0;
        end else begin
            comp_q <= compliance_disparity_force_i;
            if (compliance_disparity_force_i && !comp_q) begin
                rd <= 1'b0;
            end else if ((tx_state == TX_SEND) && tx_enable) begin
                rd <= enc[10];
            end
        end
    end

    // Receive polarity is applied at the first register, before decoding.
    symbol_t rx_sym;
    logic rx_sym_v;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_sym <= '0;
            rx_sym_v <= 1'b0;
        end else begin
            rx_sym <= rx_polarity_flip_i ? ~rx_symbol_i : rx_symbol_i;
            rx_sym_v <= rx_symbol_valid_i;
        end
    end

    // Transmit symbol; in loopback the received symbols go straight back out.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_symbol_o <= '0;
            tx_symbol_valid_o <= 1'b0;
        end else if (loopback_active_o && !tx_idle_force_i) begin
            tx_symbol_o <= rx_sym;
            tx_symbol_valid_o <= rx_sym_v;
        end else if ((tx_state == TX_SEND) && tx_enable) begin
            tx_symbol_o <= enc[9:0];
            tx_symbol_valid_o <= 1'b1;
        end else begin
            tx_symbol_valid_o <= 1'b0;
        end
    end

    // Receiver detect and loopback share one input; the power state picks the meaning.
    logic pres_s1;
    logic pres_s2;
    logic det_req_q;
    logic det_start;
    logic [7:0] det_cnt;
    assign det_start = lane_detect_or_loopback_i && (pstate == PWR_P1) && !det_req_q
                       && !pma_detect_en_o;

    // Presence comes from the analog side, so it is synchronised first.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pres_s1 <= 1'b0;
            pres_s2 <= 1'b0;
        end else begin
            pres_s1 <= pma_rx_present_i;
            pres_s2 <= pres_s1;
        end
    end

    // Detect runs a fixed time, then reports presence with a one-cycle status pulse.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            det_req_q <= 1'b0;
            det_cnt <= 8'h00;
            pma_detect_en_o <= 1'b0;
            phy_status_o <= 1'b0;
            receiver_detected_o <= 1'b0;
            loopback_active_o <= 1'b0;
        end else begin
            det_req_q <= lane_detect_or_loopback_i && (pstate == PWR_P1);
            loopback_active_o <= lane_detect_or_loopback_i && (pstate == PWR_P0);
            phy_status_o <= 1'b0;
            if (det_start) begin
                pma_detect_en_o <= 1'b1;
                det_cnt <= DET_LOAD;
            end else if (pma_detect_en_o && (det_cnt == 8'h00)) begin
                pma_detect_en_o <= 1'b0;
                receiver_detected_o <= pres_s2;
                phy_status_o <= 1'b1;
            end else if (pma_detect_en_o) begin
                det_cnt <= det_cnt - 8'h01;
            end
        end
    end

    // Elastic buffer: skips are dropped when near full and repeated when near empty.
    logic [9:0] dec;
    logic skip_in;
    logic eb_in_valid;
    logic eb_out_valid;
    logic eb_out_ready;
    logic [9:0] eb_out_data;
    logic [4:0] eb_level;
    logic head_skip;
    logic ins_now;
    logic ins_done;
    assign dec = dec8b10b(rx_sym);
    assign skip_in = !dec[9] && dec[8] && (dec[7:0] == `SKIP_BYTE);
    assign eb_in_valid = rx_sym_v && !(skip_in && (eb_level >= `EB_HIGH));
    assign head_skip = !eb_out_data[9] && eb_out_data[8] && (eb_out_data[7:0] == `SKIP_BYTE);
    assign ins_now = head_skip && (eb_level < `EB_LOW) && !ins_done;
    assign eb_out_ready = rx_ready_i && !ins_now;

    // The receive stream cannot be stalled, so an overflow past the full buffer depth is lost.
    lane_fifo #(
        .WIDTH(10),
        .DEPTH(`EB_DEPTH)
    ) elastic_buf (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(eb_in_valid),
        .in_ready_o(),
        .in_data_i(dec),
        .out_valid_o(eb_out_valid),
        .out_ready_i(eb_out_ready),
        .out_data_o(eb_out_data),
        .level_o(eb_level)
    );

    // One extra copy per skip at most, so a low level cannot stall the stream.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ins_done <= 1'b0;
        end else if (eb_out_valid && rx_ready_i) begin
            ins_done <= ins_now;
        end
    end

    assign rx_valid_o = eb_out_valid;
    assign rx_data_o = eb_out_data[7:0];
    assign rx_ctrl_flag_o = eb_out_data[8];
    assign rx_code_err_o = eb_out_data[9];

    sequence s_word_taken;
        (tx_state == TX_IDLE) && q_valid && q_ready;
    endsequence
    sequence s_first_byte;
        (tx_state == TX_SEND) && (idx == 3'h0);
    endsequence

    byte_order_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_word_taken |=> s_first_byte) else $error("word did not start at byte zero");
    hard_width_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (tx_state == TX_SEND) && !word[44] |-> (idx <= 3'h3) && (word[39:32] == 8'h00))
        else $error("hard mode used the upper byte");
    loopback_enter_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        lane_detect_or_loopback_i && (pstate == PWR_P0) |=> loopback_active_o
        ##1 (tx_symbol_o == $past(rx_sym))) else $error("loopback not entered");
    detect_start_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        det_start |=> pma_detect_en_o [*8]) else $error("detect did not start");
    detect_done_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(pma_detect_en_o) |-> ##[1:DET_MAX] phy_status_o)
        else $error("detect never reported");
    idle_force_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tx_idle_force_i |=> tx_elec_idle_o && !tx_symbol_valid_o)
        else $error("idle input ignored");
    lane_off_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        lane_off_req |=> lane_off_o && (pma_power_o == PWR_P2))
        else $error("lane not turned off");
    comp_disparity_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(compliance_disparity_force_i) |=> !rd) else $error("disparity not forced");
    rx_polarity_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rx_polarity_flip_i |=> (rx_sym == ~$past(rx_symbol_i)))
        else $error("polarity not inverted");
    skip_drop_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rx_sym_v && skip_in && (eb_level >= `EB_HIGH) |=> (eb_level <= $past(eb_level)))
        else $error("skip written above watermark");
    ref_select_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ##1 (cdr_ref_from_fabric_o == $past(lane_recovery_ref_from_fabric_i)))
        else $error("reference select not followed");
endmodule : pipe_pcs_lane

/* hw/pipe_lane_regs.svh */
// Constants for the lane coding layer: timing counts, symbols and buffer levels.
`ifndef PIPE_LANE_REGS_SVH
`define PIPE_LANE_REGS_SVH

// Interface clock rate in MHz.
`define CLK_MHZ 125
// Time the receiver detect pulse is held on the attachment, in ns.
`define DETECT_TIME_NS 1000
// Detect time in clock cycles, rounded up.
`define DETECT_CYCLES ((`DETECT_TIME_NS * `CLK_MHZ + 999) / 1000)
// Skip character payload, sent as a control symbol.
`define SKIP_BYTE 8'h1C
// Buffer depths and the elastic buffer watermarks.
`define TXQ_DEPTH 16
`define EB_DEPTH 16
`define EB_HIGH 5'h0C
`define EB_LOW 5'h04
// Index of the last byte of a word with and without the fifth byte.
`define LAST_BYTE_SOFT 3'h4
`define LAST_BYTE_HARD 3'h3

`endif

/* hw/pipe_lane_pkg.sv */
// Types shared by the lane coding layer.
package pipe_lane_pkg;
    typedef enum logic [1:0] {
        PWR_P0 = 2'b00,
        PWR_P0S = 2'b01,
        PWR_P1 = 2'b10,
        PWR_P2 = 2'b11
    } power_state_e;
    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } tx_state_e;
    typedef logic [9:0] symbol_t;
endpackage : pipe_lane_pkg

/* hw/lane_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides and a fill level.
`timescale 1ns/1ns
module lane_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Fill side.
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    // Number of words held.
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic push;
    logic pop;

    // Full and empty come straight from the level, so neither can lie.
    assign in_ready_o = (level_o != DEPTH[AW:0]);
    assign out_valid_o = (level_o != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Storage is written without reset; only the pointers and the level need a known value.
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and level.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level_o <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                level_o <= level_o + 1'b1;
            end else if (pop && !push) begin
                level_o <= level_o - 1'b1;
            end
        end
    end
endmodule : lane_fifo

/* testbench/pcs_far_end.sv */
// Model of the lane attachment: wraps transmitted symbols back and answers receiver detection.
`timescale 1ns/1ns
module pcs_far_end (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Symbols from the lane transmitter.
    input wire logic [9:0] sym_i,
    input wire logic sym_valid_i,
    input wire logic invert_i,
    // Symbols back to the lane receiver.
    output logic [9:0] sym_o,
    output logic sym_valid_o,
    output logic present_o
);
    // Everything changes on the one interface clock edge.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sym_o <= 10'h155;
            sym_valid_o <= 1'b0;
        end else if (sym_valid_i) begin
            // A swapped pair arrives inverted.
            sym_o <= invert_i ? ~sym_i : sym_i;
            sym_valid_o <= 1'b1;
        end else begin
            // Idle wire toggles so a stale symbol is never mistaken for data.
            sym_o <= ~sym_o;
            sym_valid_o <= 1'b0;
        end
    end

    // A remote receiver is always attached in this model.
    assign present_o = 1'b1;
    // Full duplex: the lane reference is the same interface clock, so it runs
    // at exactly the recovered rate and never wanders.
endmodule : pcs_far_end

/* testbench/test_pipe_pcs_lane.sv */
// Self-checking bench for one lane of the coding layer.
`timescale 1ns/1ns
module test_pipe_pcs_lane;
    import pipe_lane_pkg::*;
    logic clk_i = 1'b0, rstn_i = 1'b0, tx_valid_i = 1'b0, soft_ctrl_mode_i = 1'b0;
    logic [39:0] tx_data_i = 40'h0;
    logic [3:0] lane_tx_ctrl_flags_i = 4'h0;
    logic [1:0] power_state_select_i = 2'b10;
    logic tx_idle_force_i = 1'b0, compliance_disparity_force_i = 1'b0, flip = 1'b0;
    logic lane_detect_or_loopback_i = 1'b0, lane_recovery_ref_from_fabric_i = 1'b0;
    logic tx_ready_o, phy_status_o, receiver_detected_o, loopback_active_o, tx_symbol_valid_o;
    logic tx_elec_idle_o, lane_off_o, cdr_ref_from_fabric_o, pma_detect_en_o, present;
    logic rx_sv, rx_ctrl_flag_o, rx_code_err_o, rx_valid_o, rx_ready_i = 1'b1;
    logic [1:0] pma_power_o;
    logic [7:0] rx_data_o;
    symbol_t tx_symbol_o;
    logic [9:0] rx_sym;
    logic [9:0] got[$];
    logic [9:0] txs[$];
    int err_count = 0, n_checks = 0, cycles = 0, w;

    always #4 clk_i = ~clk_i;

    pipe_pcs_lane i_pipe_pcs_lane (.clk_i(clk_i), .rstn_i(rstn_i), .tx_data_i(tx_data_i),
        .lane_tx_ctrl_flags_i(lane_tx_ctrl_flags_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .soft_ctrl_mode_i(soft_ctrl_mode_i),
        .power_state_select_i(power_state_select_i), .tx_idle_force_i(tx_idle_force_i),
        .compliance_disparity_force_i(compliance_disparity_force_i),
        .lane_detect_or_loopback_i(lane_detect_or_loopback_i), .rx_polarity_flip_i(flip),
        .lane_recovery_ref_from_fabric_i(lane_recovery_ref_from_fabric_i),
        .phy_status_o(phy_status_o), .receiver_detected_o(receiver_detected_o),
        .loopback_active_o(loopback_active_o), .tx_symbol_o(tx_symbol_o),
        .tx_symbol_valid_o(tx_symbol_valid_o), .tx_elec_idle_o(tx_elec_idle_o),
        .lane_off_o(lane_off_o), .pma_power_o(pma_power_o),
        .cdr_ref_from_fabric_o(cdr_ref_from_fabric_o), .pma_detect_en_o(pma_detect_en_o),
        .pma_rx_present_i(present), .rx_symbol_i(rx_sym), .rx_symbol_valid_i(rx_sv),
        .rx_data_o(rx_data_o), .rx_ctrl_flag_o(rx_ctrl_flag_o), .rx_code_err_o(rx_code_err_o),
        .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i));

    pcs_far_end i_pcs_far_end (.clk_i(clk_i), .rstn_i(rstn_i), .sym_i(tx_symbol_o),
        .sym_valid_i(tx_symbol_valid_o), .invert_i(flip), .sym_o(rx_sym),
        .sym_valid_o(rx_sv), .present_o(present));

    // Monitors collect received bytes and sent symbols; a hang is cut short here.
    always @(posedge clk_i) begin
        cycles++;
        if (rx_valid_o === 1'b1) got.push_back({rx_code_err_o, rx_ctrl_flag_o, rx_data_o});
        if (tx_symbol_valid_o === 1'b1) txs.push_back(tx_symbol_o);
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic check_val(input logic [15:0] a, input logic [15:0] e);
        n_checks++;
        if (a !== e) begin
            err_count++;
            $display("[ERR] %0t value %h expected %h", $time, a, e);
        end
    endtask : check_val

    task automatic check_flag(input logic a, input logic e);
        check_val(16'(a), 16'(e));
    endtask : check_flag

    task automatic ticks(input int n);
        repeat (n) @(negedge clk_i);
    endtask : ticks

    // Word handed over when ready is seen high at a rising edge.
    task automatic send_word(input logic [39:0] d, input logic [3:0] k);
        @(negedge clk_i);
        tx_data_i = d;
        lane_tx_ctrl_flags_i = k;
        tx_valid_i = 1'b1;
        while (tx_ready_o !== 1'b1) @(negedge clk_i);
        @(negedge clk_i);
        tx_valid_i = 1'b0;
    endtask : send_word

    // Waits a bounded time for n bytes, then compares them in order.
    task automatic expect_bytes(input logic [8:0] e[$]);
        for (w = 0; w < 300 && got.size() < e.size(); w++) ticks(1);
        check_val(16'(got.size()), 16'(e.size()));
        foreach (e[i]) if (i < got.size()) check_val(16'(got[i]), 16'(e[i]));
        got.delete();
    endtask : expect_bytes

    task automatic end_of_test();
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test

    initial begin
        ticks(16);
        rstn_i = 1'b1;
        ticks(1);
        check_flag(tx_elec_idle_o, 1'b1);
        check_val(16'(pma_power_o), 16'(PWR_P1));
        lane_recovery_ref_from_fabric_i = 1'b1;
        ticks(2);
        check_flag(cdr_ref_from_fabric_o, 1'b1);
        for (int p = 3; p >= 0; p--) begin
            power_state_select_i = 2'(p);
            ticks(3);
            check_val(16'(pma_power_o), 16'(p));
            check_flag(tx_elec_idle_o, p != 0);
        end
        soft_ctrl_mode_i = 1'b1;
        send_word(40'h44_33_22_11_BC, 4'h1);
        expect_bytes('{9'h1BC, 9'h011, 9'h022, 9'h033, 9'h044});
        soft_ctrl_mode_i = 1'b0;
        send_word(40'hFF_88_77_66_55, 4'h0);
        expect_bytes('{9'h055, 9'h066, 9'h077, 9'h088});
        flip = 1'b1;
        send_word(40'h00_0A_0B_0C_0D, 4'h0);
        expect_bytes('{9'h00D, 9'h00C, 9'h00B, 9'h00A});
        flip = 1'b0;
        // A skip at the head of a shallow buffer is handed out twice.
        send_word(40'h00_04_03_02_1C, 4'h1);
        expect_bytes('{9'h11C, 9'h11C, 9'h002, 9'h003, 9'h004});
        // Queue fills while idle is forced, then drains once it drops.
        txs.delete();
        tx_idle_force_i = 1'b1;
        for (int i = 0; i < 16; i++) begin
            send_word({8'h0, 8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)}, 4'h0);
        end
        check_flag(tx_ready_o, 1'b0);
        check_val(16'(txs.size()), 16'h0000);
        check_flag(tx_elec_idle_o, 1'b1);
        tx_idle_force_i = 1'b0;
        for (w = 0; w < 400 && got.size() < 64; w++) ticks(1);
        check_val(16'(got.size()), 16'h0040);
        foreach (got[i]) check_val(16'(got[i]), 16'(i));
        got.delete();
        txs.delete();
        // Compliance pushes the disparity negative: zero byte uses the negative column.
        compliance_disparity_force_i = 1'b1;
        ticks(2);
        send_word(40'h0, 4'h0);
        for (w = 0; w < 50 && txs.size() < 1; w++) ticks(1);
        if (txs.size() > 0) check_val(16'(txs[0]), 16'h0274);
        else check_val(16'h0000, 16'h0274);
        compliance_disparity_force_i = 1'b0;
        ticks(10);
        got.delete();
        compliance_disparity_force_i = 1'b1;
        tx_idle_force_i = 1'b1;
        ticks(3);
        check_flag(lane_off_o, 1'b1);
        check_val(16'(pma_power_o), 16'(PWR_P2));
        compliance_disparity_force_i = 1'b0;
        tx_idle_force_i = 1'b0;
        lane_detect_or_loopback_i = 1'b1;
        ticks(3);
        check_flag(loopback_active_o, 1'b1);
        lane_detect_or_loopback_i = 1'b0;
        power_state_select_i = PWR_P1;
        ticks(3);
        lane_detect_or_loopback_i = 1'b1;
        ticks(2);
        check_flag(pma_detect_en_o, 1'b1);
        for (w = 0; w < 300 && phy_status_o !== 1'b1; w++) ticks(1);
        check_flag(phy_status_o, 1'b1);
        check_flag(receiver_detected_o, 1'b1);
        ticks(2);
        check_flag(pma_detect_en_o, 1'b0);
        lane_detect_or_loopback_i = 1'b0;
        end_of_test();
    end
endmodule : test_pipe_pcs_lane
